// File: common/pxg_pkg.sv
package pxg_pkg;
  localparam int unsigned PXG_NUM_PINS = 6;
  localparam int unsigned PXG_AW       = 8;
  localparam int unsigned PXG_DW       = 8;
  // register offsets
  localparam logic [7:0] PXG_OFS_PIN_DRIVE_HIGH  = 8'h10;
  localparam logic [7:0] PXG_OFS_PIN_DRIVE_LOW   = 8'h11;
  localparam logic [7:0] PXG_OFS_PIN_LEVEL_MON   = 8'h12;
  localparam logic [7:0] PXG_OFS_PIN_DIRECTION   = 8'h13;
  localparam logic [7:0] PXG_OFS_EDGE_FLAGS      = 8'h14;
  localparam logic [7:0] PXG_OFS_RISING_ARM      = 8'h15;
  localparam logic [7:0] PXG_OFS_FALLING_ARM     = 8'h16;
  localparam logic [7:0] PXG_OFS_FUNC_SELECT     = 8'h17;
  // reset values
  localparam logic [7:0] PXG_RST_DIRECTION   = 8'h00;
  localparam logic [7:0] PXG_RST_EDGE_FLAGS  = 8'h00;
  localparam logic [7:0] PXG_RST_RISING_ARM  = 8'h00;
  localparam logic [7:0] PXG_RST_FALLING_ARM = 8'h00;
  localparam logic [7:0] PXG_RST_FUNC_SELECT = 8'h0f;
  localparam logic [7:0] PXG_RST_OUT_LEVEL   = 8'h00;
  // power-on release: cycles the supply-good level must stand before release
  localparam int unsigned PXG_POR_HOLD_CYC = 4;
endpackage

// File: rtl/pxg_por_sync.sv
`timescale 1ns/1ps
module pxg_por_sync
  import pxg_pkg::*;
#(
  parameter int unsigned HOLD_CYC = PXG_POR_HOLD_CYC
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic io_supply_ok_i,
  output logic      core_rst_o
);
  localparam int unsigned CW = $clog2(HOLD_CYC + 1);

  logic          sup_meta_ff;
  logic          sup_sync_ff;
  logic [CW-1:0] hold_cnt_ff;
  logic          core_rst_ff;

  // two-flop synchroniser; supply-good is not assumed clean
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sup_meta_ff <= 1'b0;
      sup_sync_ff <= 1'b0;
    end else begin
      sup_meta_ff <= io_supply_ok_i;
      sup_sync_ff <= sup_meta_ff;
    end
  end

  // stays in reset until supply has been valid for HOLD_CYC cycles
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt_ff <= '0;
      core_rst_ff <= 1'b1;
    end else if (!sup_sync_ff) begin
      hold_cnt_ff <= '0;
      core_rst_ff <= 1'b1;
    end else if (hold_cnt_ff != CW'(HOLD_CYC)) begin
      hold_cnt_ff <= hold_cnt_ff + CW'(1);
      core_rst_ff <= 1'b1;
    end else begin
      core_rst_ff <= 1'b0;
    end
  end

  assign core_rst_o = core_rst_ff;
endmodule

// File: rtl/pxg_gpio_ctrl.sv
// Operation
// - level monitor reads live pins, writes ignored
// - direction bit 0 input, 1 driven output
// - direction register resets to all zero
// - power-up leaves every pin undriven input
// - edge flags mark detected edges, reset zero
// - rising arm bit enables rising detection
// - armed edge sets that pin's flag
// - falling arm bit enables falling detection, same flags
// - function select 0 touch/ADC, 1 GPIO; reset 0x0f
// - held in reset until I/O supply valid
// - writing 1 to drive-high sets pin high
// - writing 1 to drive-low sets pin low
`timescale 1ns/1ps
module pxg_gpio_ctrl
  import pxg_pkg::*;
#(
  parameter int unsigned NUM_PINS = PXG_NUM_PINS,
  parameter int unsigned POR_HOLD = PXG_POR_HOLD_CYC
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire logic                io_supply_ok_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [PXG_AW-1:0]   reg_addr_i,
  input  wire logic [PXG_DW-1:0]   reg_wdata_i,
  output logic      [PXG_DW-1:0]   reg_rdata_o,
  output logic                     reg_rvalid_o,
  input  wire logic [NUM_PINS-1:0] pin_i,
  output logic      [NUM_PINS-1:0] pin_o,
  output logic      [NUM_PINS-1:0] pin_oe_o,
  output logic      [NUM_PINS-1:0] pin_gpio_mode_o
);
  localparam int unsigned NP = NUM_PINS;

  logic          core_rst;
  logic [NP-1:0] pin_meta_ff;
  logic [NP-1:0] pin_sync_ff;
  logic [NP-1:0] pin_prev_ff;
  logic [NP-1:0] direction_ff;
  logic [NP-1:0] out_level_ff;
  logic [NP-1:0] edge_flags_ff;
  logic [NP-1:0] rising_arm_ff;
  logic [NP-1:0] falling_arm_ff;
  logic [NP-1:0] func_sel_ff;
  logic [NP-1:0] pin_o_ff;
  logic [NP-1:0] pin_oe_ff;
  logic [NP-1:0] gpio_mode_ff;
  logic [PXG_DW-1:0] rdata_ff;
  logic          rvalid_ff;
  logic [NP-1:0] wdata_np;
  logic [NP-1:0] edge_hit;
  logic [NP-1:0] nxt_edge_flags;
  logic [NP-1:0] nxt_out_level;
  logic [PXG_DW-1:0] nxt_rdata;
  logic          wr_drive_high;
  logic          wr_drive_low;
  logic          wr_flags;
  logic          wr_dir;
  logic          wr_rise;
  logic          wr_fall;
  logic          wr_func;

  // supply loss resets every register below, just as rst_i does
  pxg_por_sync #(
    .HOLD_CYC (POR_HOLD)
  ) u_por (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .io_supply_ok_i (io_supply_ok_i),
    .core_rst_o     (core_rst)
  );

  assign wdata_np = reg_wdata_i[NP-1:0];

  // decoded write strobes; writes to the monitor offset match nothing here
  assign wr_drive_high = reg_wr_i && reg_addr_i == PXG_OFS_PIN_DRIVE_HIGH;
  assign wr_drive_low  = reg_wr_i && reg_addr_i == PXG_OFS_PIN_DRIVE_LOW;
  assign wr_flags      = reg_wr_i && reg_addr_i == PXG_OFS_EDGE_FLAGS;
  assign wr_dir        = reg_wr_i && reg_addr_i == PXG_OFS_PIN_DIRECTION;
  assign wr_rise       = reg_wr_i && reg_addr_i == PXG_OFS_RISING_ARM;
  assign wr_fall       = reg_wr_i && reg_addr_i == PXG_OFS_FALLING_ARM;
  assign wr_func       = reg_wr_i && reg_addr_i == PXG_OFS_FUNC_SELECT;

  // pin synchroniser; only the second stage is read
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // one history stage for the edge compare
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      pin_prev_ff <= '0;
    end else begin
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // one-cycle hit per transition since prev follows sync
  for (genvar gi = 0; gi < NP; gi++) begin : g_edge
    logic rise_seen;
    logic fall_seen;

    assign rise_seen    = pin_sync_ff[gi] & ~pin_prev_ff[gi];
    assign fall_seen    = ~pin_sync_ff[gi] & pin_prev_ff[gi];
    assign edge_hit[gi] = (rising_arm_ff[gi] & rise_seen)
                        | (falling_arm_ff[gi] & fall_seen);
  end

  // set beats write-one-to-clear in the same cycle
  always_comb begin
    nxt_edge_flags = edge_flags_ff;
    if (wr_flags) begin
      nxt_edge_flags = edge_flags_ff & ~wdata_np;
    end
    nxt_edge_flags = nxt_edge_flags | edge_hit;
  end

  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      edge_flags_ff <= PXG_RST_EDGE_FLAGS[NP-1:0];
    end else begin
      edge_flags_ff <= nxt_edge_flags;
    end
  end

  always_comb begin
    nxt_out_level = out_level_ff;
    if (wr_drive_high) begin
      nxt_out_level = out_level_ff | wdata_np;
    end else if (wr_drive_low) begin
      nxt_out_level = out_level_ff & ~wdata_np;
    end
  end

  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      out_level_ff <= PXG_RST_OUT_LEVEL[NP-1:0];
    end else begin
      out_level_ff <= nxt_out_level;
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      direction_ff   <= PXG_RST_DIRECTION[NP-1:0];
      rising_arm_ff  <= PXG_RST_RISING_ARM[NP-1:0];
      falling_arm_ff <= PXG_RST_FALLING_ARM[NP-1:0];
      func_sel_ff    <= PXG_RST_FUNC_SELECT[NP-1:0];
    end else begin
      if (wr_dir) begin
        direction_ff <= wdata_np;
      end
      if (wr_rise) begin
        rising_arm_ff <= wdata_np;
      end
      if (wr_fall) begin
        falling_arm_ff <= wdata_np;
      end
      if (wr_func) begin
        func_sel_ff <= wdata_np;
      end
    end
  end

  // pin drive; a touch/ADC pin is released so the alternate function owns it
  // latch follows set/clear on inputs too, so a later direction change drives it
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      pin_o_ff     <= '0;
      pin_oe_ff    <= '0;
      gpio_mode_ff <= PXG_RST_FUNC_SELECT[NP-1:0];
    end else begin
      pin_o_ff     <= nxt_out_level;
      pin_oe_ff    <= direction_ff & func_sel_ff;
      gpio_mode_ff <= func_sel_ff;
    end
  end

  // read mux; monitor is read-only, writes to it fall through
  // drive offsets read back the latch and its inverse
  always_comb begin
    nxt_rdata = '0;
    unique case (reg_addr_i)
      PXG_OFS_PIN_DRIVE_HIGH: nxt_rdata[NP-1:0] = out_level_ff;
      PXG_OFS_PIN_DRIVE_LOW:  nxt_rdata[NP-1:0] = ~out_level_ff;
      PXG_OFS_PIN_LEVEL_MON:  nxt_rdata[NP-1:0] = pin_sync_ff;
      PXG_OFS_PIN_DIRECTION:  nxt_rdata[NP-1:0] = direction_ff;
      PXG_OFS_EDGE_FLAGS:     nxt_rdata[NP-1:0] = edge_flags_ff;
      PXG_OFS_RISING_ARM:     nxt_rdata[NP-1:0] = rising_arm_ff;
      PXG_OFS_FALLING_ARM:    nxt_rdata[NP-1:0] = falling_arm_ff;
      PXG_OFS_FUNC_SELECT:    nxt_rdata[NP-1:0] = func_sel_ff;
      default:                nxt_rdata = '0;
    endcase
  end

  // answer strobe: one cycle after each read
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_i;
    end
  end

  // read data holds until the next read
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      rdata_ff <= '0;
    end else if (reg_rd_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o     = rdata_ff;
  assign reg_rvalid_o    = rvalid_ff;
  assign pin_o           = pin_o_ff;
  assign pin_oe_o        = pin_oe_ff;
  assign pin_gpio_mode_o = gpio_mode_ff;
endmodule

// File: dv/pxg_gpio_ctrl_asserts.sv
`timescale 1ns/1ps
module pxg_gpio_asserts
  import pxg_pkg::*;
#(
  parameter int unsigned POR_HOLD = 4
) (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       io_supply_ok_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       reg_rvalid_o,
  input wire logic [5:0] pin_i,
  input wire logic [5:0] pin_o,
  input wire logic [5:0] pin_oe_o,
  input wire logic [5:0] pin_gpio_mode_o
);
  // internal reset is hidden; count well past its release before trusting the bus
  logic [4:0] up_ff;
  wire        live = up_ff >= 5'(POR_HOLD + 8);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) up_ff <= 5'h00;
    else if (!io_supply_ok_i) up_ff <= 5'h00;
    else if (!live) up_ff <= up_ff + 5'h01;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_mon_rd;
    live && reg_rd_i && reg_addr_i == PXG_OFS_PIN_LEVEL_MON;
  endsequence
  sequence s_dir_wr;
    live && reg_wr_i && reg_addr_i == PXG_OFS_PIN_DIRECTION;
  endsequence
  a_rd_answer: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("rvalid without read");
  a_mon_live: assert property ($stable(pin_i) [*4] ##0 s_mon_rd |=> reg_rdata_o == {2'b00, $past(pin_i)})
    else $error("monitor not live level");
  a_oe_gpio_only: assert property ((pin_oe_o & ~pin_gpio_mode_o) == 6'h00) else $error("drive in alt mode");
  a_dir_drive: assert property (s_dir_wr ##1 !reg_wr_i |=> pin_oe_o == ($past(reg_wdata_i[5:0], 2) & pin_gpio_mode_o))
    else $error("enable not direction");
  a_rst_state: assert property (disable iff (1'b0) rst_i |-> pin_oe_o == 6'h00 && pin_o == 6'h00 && pin_gpio_mode_o == 6'h0f)
    else $error("bad reset state");
  a_supply_hold: assert property (!io_supply_ok_i [*6] |-> pin_oe_o == 6'h00 && !reg_rvalid_o)
    else $error("active without supply");
  a_set_high: assert property (live && reg_wr_i && reg_addr_i == PXG_OFS_PIN_DRIVE_HIGH |=>
    (pin_o & $past(reg_wdata_i[5:0])) == $past(reg_wdata_i[5:0])) else $error("set missed");
  a_clr_low: assert property (live && reg_wr_i && reg_addr_i == PXG_OFS_PIN_DRIVE_LOW |=>
    (pin_o & $past(reg_wdata_i[5:0])) == 6'h00) else $error("clear missed");
  a_out_steady: assert property (live && !(reg_wr_i && reg_addr_i inside {8'h10, 8'h11}) |=> $stable(pin_o))
    else $error("level moved unasked");
endmodule
bind pxg_gpio_ctrl pxg_gpio_asserts #(.POR_HOLD(POR_HOLD)) i_chk (.ref_clk_i, .rst_i, .io_supply_ok_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .pin_i, .pin_o, .pin_oe_o, .pin_gpio_mode_o);

// File: dv/pxg_pin_model.sv
`timescale 1ns/1ps
module pxg_pin_model (
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe_o,
  input  wire logic [5:0] ext_lvl_i,
  output logic      [5:0] pin_level_o
);
  // driven pins read back the device level, the rest the board level
  assign pin_level_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_lvl_i);
endmodule

// File: dv/tb_pin_expander_gpio_control.sv
`timescale 1ns/1ps
module tb_pin_expander_gpio_control
  import pxg_pkg::*;
();
  logic       clk = 0, rst = 0, sup = 1, wr = 0, rd = 0, rv;
  logic [7:0] addr = 0, wd = 0, rdat;
  logic [5:0] ext = 0, pin, po, oe, gm, out, fl, r, f, d, a, b;
  int         n_mismatch = 0, tests_run = 0;
  pxg_gpio_ctrl i_dut (.ref_clk_i(clk), .rst_i(rst), .io_supply_ok_i(sup), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv), .pin_i(pin), .pin_o(po),
    .pin_oe_o(oe), .pin_gpio_mode_o(gm));
  pxg_pin_model i_pins (.pin_o(po), .pin_oe_o(oe), .ext_lvl_i(ext), .pin_level_o(pin));
  initial forever #2 clk = ~clk;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, e, input string m);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] ad, dt);
    tick();
    wr = 1;
    addr = ad;
    wd = dt;
    tick();
    wr = 0;
  endtask
  task automatic rchk(input logic [7:0] ad, e, input string m);
    tick();
    rd = 1;
    addr = ad;
    tick();
    rd = 0;
    for (int i = 0; i < 3 && rv !== 1'b1; i++) tick();
    if (rv !== 1'b1) begin
      chk(8'h00, 8'h01, "no read answer");
      report_and_stop();
    end else begin
      chk(rdat, e, m);
    end
  endtask
  function automatic logic [5:0] edges(input logic [5:0] o, n, ri, fa);
    return (~o & n & ri) | (o & ~n & fa);
  endfunction
  initial begin
    void'($urandom(32'h1ea0));
    #1 rst = 1;
    tick(3);
    rst = 0;
    tick(16);
    rchk(8'h13, 8'h00, "dir reset");
    rchk(8'h14, 8'h00, "flag reset");
    rchk(8'h15, 8'h00, "rise reset");
    rchk(8'h16, 8'h00, "fall reset");
    rchk(8'h17, 8'h0f, "func reset");
    chk({2'b00, oe}, 8'h00, "undriven");
    rchk(8'h1f, 8'h00, "unmapped");
    $display("test reset done");
    wreg(8'h17, 8'h3f);
    out = 0;
    repeat (12) begin
      d = 6'($urandom);
      a = 6'($urandom);
      b = 6'($urandom);
      ext = 6'($urandom);
      wreg(8'h13, {2'b00, d});
      wreg(8'h10, {2'b11, a});
      wreg(8'h11, {2'b00, b});
      out = (out | a) & ~b;
      wreg(8'h12, 8'(~{2'b00, ext}));
      chk({2'b00, po}, {2'b00, out}, "level");
      chk({2'b00, oe}, {2'b00, d}, "enable");
      rchk(8'h12, {2'b00, (d & out) | (~d & ext)}, "monitor");
    end
    a = 6'($urandom);
    wreg(8'h17, {2'b00, a});
    tick(2);
    chk({2'b00, gm}, {2'b00, a}, "mode");
    chk({2'b00, oe}, {2'b00, a & d}, "mode enable");
    $display("test drive done");
    wreg(8'h13, 8'h00);
    wreg(8'h17, 8'h3f);
    r = 6'($urandom);
    f = 6'($urandom);
    fl = 0;
    wreg(8'h15, {2'b00, r});
    wreg(8'h16, {2'b00, f});
    wreg(8'h14, 8'h3f);
    repeat (10) begin
      a = ext;
      ext = 6'($urandom);
      tick(4);
      fl = fl | edges(a, ext, r, f);
      rchk(8'h14, {2'b00, fl}, "flags");
      b = 6'($urandom);
      wreg(8'h14, {2'b00, b});
      fl = fl & ~b;
      rchk(8'h14, {2'b00, fl}, "clear");
    end
    wreg(8'h15, 8'h3f);
    ext = 6'h00;
    tick(4);
    wreg(8'h14, 8'h3f);
    ext = 6'h3f;
    tick();
    wreg(8'h14, 8'h3f);
    rchk(8'h14, 8'h3f, "set beats clear");
    $display("test edge done");
    wreg(8'h13, 8'h3f);
    sup = 0;
    tick(8);
    chk({2'b00, oe}, 8'h00, "supply off");
    sup = 1;
    tick(3);
    chk({2'b00, oe}, 8'h00, "still held");
    wreg(8'h13, 8'h3f);
    tick(12);
    rchk(8'h13, 8'h00, "dir after supply");
    $display("test supply done");
    report_and_stop();
  end
endmodule
